/* File: verilog/crs_consts.svh */
// constants for the programmer register set: offsets, fields, resets
`ifndef CRS_CONSTS_SVH
`define CRS_CONSTS_SVH
// register word indices on the avalon slave
`define CRS_IDX_ACC     3'h0
`define CRS_IDX_INDEX   3'h1
`define CRS_IDX_STACK   3'h2
`define CRS_IDX_IADDR   3'h3
`define CRS_IDX_FLAGS   3'h4
`define CRS_IDX_STATUS  3'h5
// flag bit positions
`define CRS_F_V         7
`define CRS_F_H         4
`define CRS_F_I         3
`define CRS_F_N         2
`define CRS_F_Z         1
`define CRS_F_C         0
// bits 6 and 5 always read one
`define CRS_F_ONES      8'h60
// reset values and vectors
`define CRS_SP_RST      16'h00FF
`define CRS_SP_LO_RLD   8'hFF
`define CRS_VEC_RST_HI  16'hFFFE
`define CRS_VEC_RST_LO  16'hFFFF
`define CRS_IVEC_TOP    16'hFFFC
`define CRS_FLG_RST     8'h08
`define CRS_STK_LAST    3'h4
// frame slot order while stacking and unstacking
`define CRS_PSH_PCL     3'h0
`define CRS_PSH_PCH     3'h1
`define CRS_PSH_IDX     3'h2
`define CRS_PSH_ACC     3'h3
`define CRS_PUL_FLG     3'h0
`define CRS_PUL_ACC     3'h1
`define CRS_PUL_IDX     3'h2
`define CRS_PUL_PCH     3'h3
`endif

/* File: verilog/crs_pkg.sv */
// types shared by the programmer register set
package crs_pkg;
	typedef enum logic [3:0] {
		CRS_OP_NOP, CRS_OP_ALU, CRS_OP_LD_H, CRS_OP_LD_X, CRS_OP_LD_SP,
		CRS_OP_RSP, CRS_OP_PUSH_H, CRS_OP_PULL_H, CRS_OP_FETCH, CRS_OP_JUMP,
		CRS_OP_CLI, CRS_OP_SEI, CRS_OP_RTI, CRS_OP_EA_IX, CRS_OP_EA_SP
	} crs_op_e;
	typedef enum logic [2:0] {
		CRS_ALU_ADD, CRS_ALU_ADC, CRS_ALU_SUB, CRS_ALU_AND,
		CRS_ALU_ORA, CRS_ALU_EOR, CRS_ALU_ASL, CRS_ALU_LSR
	} crs_alu_e;
	// one command from the instruction decoder
	typedef struct packed {
		crs_op_e    op;
		crs_alu_e   alu;
		logic [7:0] byte_v;
		logic [15:0] word_v;
	} crs_cmd_s;
	// one memory access, read data returns in the same cycle
	typedef struct packed {
		logic        rd;
		logic        wr;
		logic [15:0] addr;
		logic [7:0]  wdata;
	} crs_mem_s;
	// alu result with flags
	typedef struct packed {
		logic [7:0] res;
		logic       v;
		logic       h;
		logic       n;
		logic       z;
		logic       c;
	} crs_alu_s;
endpackage

/* File: verilog/crs_alu.sv */
// eight-bit arithmetic and logic unit with flag outputs
`timescale 1ns/10ps
module crs_alu
	import crs_pkg::*;
(
	// operands
	input  wire logic [7:0] a_i,
	input  wire logic [7:0] m_i,
	input  wire logic       cin_i,
	input  wire crs_alu_e   op_i,
	// result
	output crs_alu_s        out_o
);
	logic [8:0] sum;     // nine bits keep the carry out of bit 7
	logic [4:0] nib;     // low nibble sum exposes the bit 3 carry
	logic       cadd;    // carry in used by add with carry
	always_comb begin
		cadd = (op_i == CRS_ALU_ADC) ? cin_i : 1'b0;
		sum = 9'h000;
		nib = {1'b0, a_i[3:0]} + {1'b0, m_i[3:0]} + {4'h0, cadd};
		out_o = '0;
		out_o.c = cin_i;
		case (op_i)
			CRS_ALU_ADD, CRS_ALU_ADC: begin
				sum = {1'b0, a_i} + {1'b0, m_i} + {8'h00, cadd};
				out_o.res = sum[7:0];
				out_o.c = sum[8]; // RQ21
				out_o.h = nib[4]; // RQ12
				out_o.v = (a_i[7] == m_i[7]) && (sum[7] != a_i[7]); // RQ11
			end
			CRS_ALU_SUB: begin
				sum = {1'b0, a_i} - {1'b0, m_i};
				out_o.res = sum[7:0];
				out_o.c = sum[8]; // RQ21
				out_o.v = (a_i[7] != m_i[7]) && (sum[7] != a_i[7]); // RQ11
			end
			CRS_ALU_AND: out_o.res = a_i & m_i;
			CRS_ALU_ORA: out_o.res = a_i | m_i;
			CRS_ALU_EOR: out_o.res = a_i ^ m_i;
			CRS_ALU_ASL: begin
				out_o.res = {a_i[6:0], 1'b0};
				out_o.c = a_i[7]; // RQ21
				out_o.v = a_i[7] ^ a_i[6];
			end
			CRS_ALU_LSR: begin
				out_o.res = {1'b0, a_i[7:1]};
				out_o.c = a_i[0]; // RQ21
				out_o.v = a_i[0];
			end
			default: out_o.res = a_i;
		endcase
		out_o.n = out_o.res[7]; // RQ19
		out_o.z = (out_o.res == 8'h00); // RQ20
	end
endmodule

/* File: verilog/crs_ea.sv */
// operand address former for indexed and stack relative modes
`timescale 1ns/10ps
module crs_ea (
	// clock and reset
	input  wire logic        core_clk_i,
	input  wire logic        rst_n_i,
	// request
	input  wire logic        ld_i,
	input  wire logic        use_sp_i,
	input  wire logic [15:0] index_i,
	input  wire logic [15:0] sp_i,
	input  wire logic [15:0] off_i,
	// formed address
	output logic      [15:0] ea_o
);
	// base plus offset, wraps within the 64k space
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			ea_o <= 16'h0000;
		end else if (ld_i) begin
			ea_o <= (use_sp_i ? sp_i : index_i) + off_i; // RQ3 RQ7
		end
	end
endmodule

/* File: verilog/crs_regset.sv */
// programmer register set: registers, stacking sequencer and avalon slave
// Behaviour
// RQ1: eight-bit accumulator feeds and takes alu results
// RQ2: sixteen-bit index from separately loaded bytes
// RQ3: indexed modes address from the index pointer
// RQ4: reset sets stack pointer to 00ff
// RQ5: reload sets low byte ff, high kept
// RQ6: push decrements, pull increments stack pointer
// RQ7: stack offset modes use stack pointer base
// RQ8: address advances per fetch, jumps load target
// RQ9: reset loads address from vector fffe/ffff
// RQ10: flag bits 6 and 5 read one
// RQ11: overflow flag marks signed overflow
// RQ12: half carry from bit 3 on adds
// RQ13: mask set ignores maskable interrupt requests
// RQ14: mask set after stacking, before vector
// RQ15: index high byte never stacked automatically
// RQ16: highest priority pending request served first
// RQ17: return restores all stacked registers and mask
// RQ18: reset sets mask, only clear instruction clears; the code also clears it when return pulls a flags byte with the mask clear
// RQ19: negative flag follows result bit 7
// RQ20: zero flag set on zero result
// RQ21: carry on add carry or subtract borrow
`timescale 1ns/10ps
`include "crs_consts.svh"
module crs_regset
	import crs_pkg::*;
#(
	parameter int IRQ_N = 4
) (
	// clock and reset
	input  wire logic             core_clk_i,
	input  wire logic             rst_n_i,
	// avalon-mm slave
	input  wire logic [2:0]       avs_address,
	input  wire logic             avs_read,
	input  wire logic             avs_write,
	input  wire logic [31:0]      avs_writedata,
	output logic      [31:0]      avs_readdata,
	output logic                  avs_waitrequest,
	// decoder command port
	input  wire logic             cmd_valid_i,
	input  crs_cmd_s              cmd_i,
	output logic                  cmd_ready_o,
	// interrupt requests, bit 0 highest priority
	input  wire logic [IRQ_N-1:0] irq_i,
	// memory port
	output crs_mem_s              mem_o,
	input  wire logic [7:0]       mem_rdata_i,
	// observed state
	output logic      [15:0]      ea_o,
	output logic      [15:0]      iaddr_o,
	output logic      [7:0]       flags_o
);
	typedef enum logic [2:0] {
		ST_VEC_HI, ST_VEC_LO, ST_RUN, ST_PUSH, ST_SETI, ST_IVH, ST_IVL, ST_PULL
	} crs_st_e;

	crs_st_e     st_q;          // sequencer state
	logic [2:0]  step_q;        // byte count while stacking
	logic [7:0]  acc_q;         // accumulator
	logic [7:0]  idx_hi_q;      // index upper byte
	logic [7:0]  idx_lo_q;      // index lower byte
	logic [15:0] sp_q;          // stack top pointer
	logic [15:0] pc_q;          // instruction address
	logic [7:0]  flg_q;         // flags and mask, bits 6 and 5 unused
	logic [15:0] ivec_q;        // vector address of the request taken
	logic        ack_q;         // avalon answer cycle
	logic        take;          // decoder command accepted
	logic        irq_take;      // interrupt entry begins
	logic        bus_ok;        // registers free for software writes
	logic        bus_req;       // avalon request present
	logic        bus_wr;        // software write takes effect
	logic [15:0] sp_up;         // address of the next byte to pull
	logic [7:0]  push_b;        // byte pushed at this step
	crs_alu_s    alu;           // alu result

	// priority encoder: lowest index wins, so order of service is fixed
	function automatic logic [15:0] vec_of(input logic [IRQ_N-1:0] r);
		logic [15:0] v;
		v = `CRS_IVEC_TOP;
		for (int i = IRQ_N - 1; i >= 0; i--) begin
			if (r[i]) begin
				v = `CRS_IVEC_TOP - 16'(2 * (i + 1));
			end
		end
		return v;
	endfunction

	// flags as seen from outside, fixed ones forced in
	function automatic logic [7:0] flg_rd(input logic [7:0] f);
		return f | `CRS_F_ONES;
	endfunction

	assign take = cmd_valid_i && cmd_ready_o;
	// a masked request is simply not seen; it waits on its line
	assign irq_take = (st_q == ST_RUN) && !flg_q[`CRS_F_I] && (|irq_i); // RQ13 RQ16
	assign cmd_ready_o = (st_q == ST_RUN) && !irq_take;
	assign sp_up = sp_q + 16'h0001;
	assign bus_req = avs_read || avs_write;
	// software writes wait while the decoder or sequencer owns the registers
	assign bus_ok = (st_q == ST_RUN) && !cmd_valid_i && !irq_take;
	// a write lands at the very edge where waitrequest is seen low, never earlier
	assign bus_wr = avs_write && bus_ok;
	assign avs_waitrequest = bus_req && (avs_read ? !ack_q : !bus_ok);
	assign iaddr_o = pc_q;
	assign flags_o = flg_rd(flg_q);

	crs_alu u_alu (
		.a_i   (acc_q),
		.m_i   (cmd_i.byte_v),
		.cin_i (flg_q[`CRS_F_C]),
		.op_i  (cmd_i.alu),
		.out_o (alu)
	);

	crs_ea u_ea (
		.core_clk_i (core_clk_i),
		.rst_n_i    (rst_n_i),
		.ld_i       (take && (cmd_i.op == CRS_OP_EA_IX || cmd_i.op == CRS_OP_EA_SP)),
		.use_sp_i   (cmd_i.op == CRS_OP_EA_SP),
		.index_i    ({idx_hi_q, idx_lo_q}),
		.sp_i       (sp_q),
		.off_i      (cmd_i.word_v),
		.ea_o       (ea_o)
	);

	// interrupt frame, index upper byte left out on purpose
	always_comb begin
		case (step_q)
			`CRS_PSH_PCL: push_b = pc_q[7:0];
			`CRS_PSH_PCH: push_b = pc_q[15:8];
			`CRS_PSH_IDX: push_b = idx_lo_q; // RQ15
			`CRS_PSH_ACC: push_b = acc_q;
			default: push_b = flg_rd(flg_q);
		endcase
	end

	// memory requests from the sequencer and the index byte stack ops
	always_comb begin
		mem_o = '0;
		case (st_q)
			ST_VEC_HI: begin
				mem_o.rd = 1'b1;
				mem_o.addr = `CRS_VEC_RST_HI; // RQ9
			end
			ST_VEC_LO: begin
				mem_o.rd = 1'b1;
				mem_o.addr = `CRS_VEC_RST_LO; // RQ9
			end
			ST_PUSH: begin
				mem_o.wr = 1'b1;
				mem_o.addr = sp_q;
				mem_o.wdata = push_b;
			end
			ST_IVH: begin
				mem_o.rd = 1'b1;
				mem_o.addr = ivec_q;
			end
			ST_IVL: begin
				mem_o.rd = 1'b1;
				mem_o.addr = ivec_q + 16'h0001;
			end
			ST_PULL: begin
				mem_o.rd = 1'b1;
				mem_o.addr = sp_up;
			end
			ST_RUN: begin
				if (take && cmd_i.op == CRS_OP_PUSH_H) begin
					mem_o.wr = 1'b1; // RQ15
					mem_o.addr = sp_q;
					mem_o.wdata = idx_hi_q;
				end else if (take && cmd_i.op == CRS_OP_PULL_H) begin
					mem_o.rd = 1'b1; // RQ15
					mem_o.addr = sp_up;
				end
			end
			default: mem_o = '0;
		endcase
	end

	// sequencer: reset vector, interrupt entry, interrupt return
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			st_q <= ST_VEC_HI;
			step_q <= 3'h0;
			ivec_q <= `CRS_IVEC_TOP;
		end else begin
			case (st_q)
				ST_VEC_HI: st_q <= ST_VEC_LO;
				ST_VEC_LO: st_q <= ST_RUN;
				ST_RUN: begin
					step_q <= 3'h0;
					if (irq_take) begin
						ivec_q <= vec_of(irq_i); // RQ16
						st_q <= ST_PUSH;
					end else if (take && cmd_i.op == CRS_OP_RTI) begin
						st_q <= ST_PULL; // RQ17
					end
				end
				ST_PUSH: begin
					step_q <= step_q + 3'h1;
					if (step_q == `CRS_STK_LAST) begin
						st_q <= ST_SETI; // RQ14
					end
				end
				ST_SETI: st_q <= ST_IVH;
				ST_IVH:  st_q <= ST_IVL;
				ST_IVL:  st_q <= ST_RUN;
				ST_PULL: begin
					step_q <= step_q + 3'h1;
					if (step_q == `CRS_STK_LAST) begin
						st_q <= ST_RUN;
					end
				end
				default: st_q <= ST_VEC_HI;
			endcase
		end
	end

	// accumulator
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			acc_q <= 8'h00;
		end else if (take && cmd_i.op == CRS_OP_ALU) begin
			acc_q <= alu.res; // RQ1
		end else if (st_q == ST_PULL && step_q == `CRS_PUL_ACC) begin
			acc_q <= mem_rdata_i; // RQ17
		end else if (bus_wr && avs_address == `CRS_IDX_ACC) begin
			acc_q <= avs_writedata[7:0];
		end
	end

	// index pointer, each byte loads on its own by command, both bytes at once from the bus
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			idx_hi_q <= 8'h00;
			idx_lo_q <= 8'h00;
		end else if (take && cmd_i.op == CRS_OP_LD_H) begin
			idx_hi_q <= cmd_i.byte_v; // RQ2
		end else if (take && cmd_i.op == CRS_OP_LD_X) begin
			idx_lo_q <= cmd_i.byte_v; // RQ2
		end else if (take && cmd_i.op == CRS_OP_PULL_H) begin
			idx_hi_q <= mem_rdata_i; // RQ15
		end else if (st_q == ST_PULL && step_q == `CRS_PUL_IDX) begin
			idx_lo_q <= mem_rdata_i; // RQ17
		end else if (bus_wr && avs_address == `CRS_IDX_INDEX) begin
			{idx_hi_q, idx_lo_q} <= avs_writedata[15:0];
		end
	end

	// stack top pointer: one step per byte moved
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			sp_q <= `CRS_SP_RST; // RQ4
		end else if (st_q == ST_PUSH) begin
			sp_q <= sp_q - 16'h0001; // RQ6
		end else if (st_q == ST_PULL) begin
			sp_q <= sp_up; // RQ6
		end else if (take) begin
			case (cmd_i.op)
				CRS_OP_LD_SP:  sp_q <= cmd_i.word_v;
				CRS_OP_RSP:    sp_q[7:0] <= `CRS_SP_LO_RLD; // RQ5
				CRS_OP_PUSH_H: sp_q <= sp_q - 16'h0001; // RQ6
				CRS_OP_PULL_H: sp_q <= sp_up; // RQ6
				default:       sp_q <= sp_q;
			endcase
		end else if (bus_wr && avs_address == `CRS_IDX_STACK) begin
			sp_q <= avs_writedata[15:0];
		end
	end

	// instruction address: vectors, fetch increment, jumps, return
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			pc_q <= 16'h0000;
		end else if (st_q == ST_VEC_HI || st_q == ST_IVH) begin
			pc_q[15:8] <= mem_rdata_i; // RQ9
		end else if (st_q == ST_VEC_LO || st_q == ST_IVL) begin
			pc_q[7:0] <= mem_rdata_i; // RQ9 RQ8
		end else if (st_q == ST_PULL && step_q == `CRS_PUL_PCH) begin
			pc_q[15:8] <= mem_rdata_i; // RQ17
		end else if (st_q == ST_PULL && step_q == `CRS_STK_LAST) begin
			pc_q[7:0] <= mem_rdata_i; // RQ17
		end else if (take && cmd_i.op == CRS_OP_FETCH) begin
			pc_q <= pc_q + 16'h0001; // RQ8
		end else if (take && cmd_i.op == CRS_OP_JUMP) begin
			pc_q <= cmd_i.word_v; // RQ8
		end else if (bus_wr && avs_address == `CRS_IDX_IADDR) begin
			pc_q <= avs_writedata[15:0];
		end
	end

	// flags and mask; bus writes can set the mask but never clear it, only commands and unstacking clear it
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			flg_q <= `CRS_FLG_RST; // RQ18
		end else if (st_q == ST_SETI) begin
			flg_q[`CRS_F_I] <= 1'b1; // RQ14
		end else if (st_q == ST_PULL && step_q == `CRS_PUL_FLG) begin
			flg_q <= mem_rdata_i & ~`CRS_F_ONES; // RQ17
		end else if (take && cmd_i.op == CRS_OP_ALU) begin
			flg_q[`CRS_F_N] <= alu.n; // RQ19
			flg_q[`CRS_F_Z] <= alu.z; // RQ20
			flg_q[`CRS_F_V] <= alu.v; // RQ11
			if (cmd_i.alu == CRS_ALU_ADD || cmd_i.alu == CRS_ALU_ADC) begin
				flg_q[`CRS_F_H] <= alu.h; // RQ12
			end
			flg_q[`CRS_F_C] <= alu.c; // RQ21
		end else if (take && cmd_i.op == CRS_OP_CLI) begin
			flg_q[`CRS_F_I] <= 1'b0; // RQ18
		end else if (take && cmd_i.op == CRS_OP_SEI) begin
			flg_q[`CRS_F_I] <= 1'b1;
		end else if (bus_wr && avs_address == `CRS_IDX_FLAGS) begin
			flg_q <= (avs_writedata[7:0] & ~`CRS_F_ONES)
				| (flg_q & (8'h01 << `CRS_F_I)); // RQ18
		end
	end

	// avalon answer: one wait cycle for reads, writes wait for a free slot
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			ack_q <= 1'b0;
			avs_readdata <= 32'h0000_0000;
		end else begin
			ack_q <= !ack_q && avs_read;
			if (avs_read && !ack_q) begin
				case (avs_address)
					`CRS_IDX_ACC:    avs_readdata <= {24'h00_0000, acc_q};
					`CRS_IDX_INDEX:  avs_readdata <= {16'h0000, idx_hi_q, idx_lo_q};
					`CRS_IDX_STACK:  avs_readdata <= {16'h0000, sp_q};
					`CRS_IDX_IADDR:  avs_readdata <= {16'h0000, pc_q};
					`CRS_IDX_FLAGS:  avs_readdata <= {24'h00_0000, flg_rd(flg_q)}; // RQ10
					`CRS_IDX_STATUS: avs_readdata <= {29'h0000_0000, |irq_i,
						flg_q[`CRS_F_I], st_q == ST_RUN};
					default:         avs_readdata <= 32'h0000_0000;
				endcase
			end
		end
	end

	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (!rst_n_i);

	property p_rsp;
		take && cmd_i.op == CRS_OP_RSP |=> sp_q[7:0] == `CRS_SP_LO_RLD
			&& sp_q[15:8] == $past(sp_q[15:8]);
	endproperty
	a_rsp: assert property (p_rsp) else $error("reload changed wrong byte"); // RQ5
	property p_push;
		take && cmd_i.op == CRS_OP_PUSH_H |=> sp_q == $past(sp_q) - 16'h0001;
	endproperty
	a_push: assert property (p_push) else $error("push did not decrement"); // RQ6
	property p_fetch;
		take && cmd_i.op == CRS_OP_FETCH |=> pc_q == $past(pc_q) + 16'h0001;
	endproperty
	a_fetch: assert property (p_fetch) else $error("fetch did not advance"); // RQ8
	property p_vec;
		st_q == ST_VEC_HI ##1 st_q == ST_VEC_LO |=>
			pc_q == {$past(mem_rdata_i, 2), $past(mem_rdata_i)};
	endproperty
	a_vec: assert property (p_vec) else $error("reset vector not loaded"); // RQ9
	property p_ones;
		avs_read && !ack_q && avs_address == `CRS_IDX_FLAGS |=> avs_readdata[6:5] == 2'b11;
	endproperty
	a_ones: assert property (p_ones) else $error("fixed flag bits not one"); // RQ10
	property p_mask;
		flg_q[`CRS_F_I] |-> !irq_take;
	endproperty
	a_mask: assert property (p_mask) else $error("masked request taken"); // RQ13
	property p_entry;
		irq_take |=> st_q == ST_PUSH [*5] ##1 st_q == ST_SETI ##1 flg_q[`CRS_F_I];
	endproperty
	a_entry: assert property (p_entry) else $error("mask not set after stack"); // RQ14
	property p_cli;
		$fell(flg_q[`CRS_F_I]) |-> $past(take && cmd_i.op == CRS_OP_CLI)
			|| $past(st_q == ST_PULL);
	endproperty
	a_cli: assert property (p_cli) else $error("mask cleared without cli"); // RQ18
	property p_zero;
		take && cmd_i.op == CRS_OP_ALU && alu.res == 8'h00 |=> flg_q[`CRS_F_Z]
			&& acc_q == 8'h00;
	endproperty
	a_zero: assert property (p_zero) else $error("zero flag wrong"); // RQ20
	property p_ea;
		take && cmd_i.op == CRS_OP_EA_IX |=>
			ea_o == $past({idx_hi_q, idx_lo_q} + cmd_i.word_v);
	endproperty
	a_ea: assert property (p_ea) else $error("indexed address wrong"); // RQ3

	c_irq: cover property (irq_take ##8 st_q == ST_IVL);
	c_rti: cover property (take && cmd_i.op == CRS_OP_RTI ##6 st_q == ST_RUN);
	c_bus: cover property (avs_write && !avs_waitrequest);
endmodule

/* File: verif/crs_mem_model.sv */
// behavioural memory seen over the register set's memory port
`timescale 1ns/10ps
module crs_mem_model
	import crs_pkg::*;
(
	// clock
	input  wire logic       core_clk_i,
	// access from the block
	input  crs_mem_s        mem_i,
	output logic      [7:0] rdata_o
);
	logic [7:0] mem_q [0:65535];	// full 64k byte space
	logic [7:0] last_q;	// last byte driven on a read

	// vectors: reset at fffe/ffff, highest request at fffa/fffb
	initial begin
		mem_q[16'hfffe] = 8'h12;
		mem_q[16'hffff] = 8'h34;
		mem_q[16'hfffa] = 8'h56;
		mem_q[16'hfffb] = 8'h78;
		last_q = 8'h00;
	end

	// read answers in the same cycle; idle shows the inverse so stale data never matches
	always_comb begin
		rdata_o = mem_i.rd ? mem_q[mem_i.addr] : ~last_q;
	end

	// writes land at the edge, read value remembered for the idle pattern
	always_ff @(posedge core_clk_i) begin
		if (mem_i.wr) begin
			mem_q[mem_i.addr] <= mem_i.wdata;
		end
		if (mem_i.rd) begin
			last_q <= mem_q[mem_i.addr];
		end
	end
endmodule

/* File: verif/cpu_programmer_register_set_bench.sv */
// self-checking bench for the programmer register set
`timescale 1ns/10ps
module cpu_programmer_register_set_bench;
	import crs_pkg::*;
	logic        core_clk_i = 1'b0;	// 50 mhz core clock
	logic        rst_n_i = 1'b0;	// reset held at start
	logic [2:0]  avs_address = 3'h0;
	logic        avs_read = 1'b0;
	logic        avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0000_0000;
	logic [31:0] avs_readdata;
	logic        avs_waitrequest;
	logic        cmd_valid_i = 1'b0;
	crs_cmd_s    cmd_i = '0;
	logic        cmd_ready_o;
	logic [3:0]  irq_i = 4'h0;
	crs_mem_s    mem_o;
	logic [7:0]  mem_rdata_i;
	logic [15:0] ea_o;
	logic [15:0] iaddr_o;
	logic [7:0]  flags_o;
	int          failures = 0;	// mismatch count
	int          check_count = 0;	// comparisons made
	int          cycles = 0;	// timeout counter
	int          wr_count = 0;	// memory writes seen
	logic [15:0] wr_addr [0:15];
	logic [7:0]  wr_data [0:15];
	logic [31:0] rd;

	always #10 core_clk_i = ~core_clk_i;

	crs_regset DUT (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
		.cmd_valid_i(cmd_valid_i), .cmd_i(cmd_i), .cmd_ready_o(cmd_ready_o), .irq_i(irq_i),
		.mem_o(mem_o), .mem_rdata_i(mem_rdata_i), .ea_o(ea_o), .iaddr_o(iaddr_o),
		.flags_o(flags_o));
	crs_mem_model mem_u (.core_clk_i(core_clk_i), .mem_i(mem_o), .rdata_o(mem_rdata_i));

	// log the first 16 memory writes so stacking order can be judged
	always @(posedge core_clk_i) begin
		if (mem_o.wr === 1'b1 && wr_count < 16) begin
			wr_addr[wr_count] <= mem_o.addr;
			wr_data[wr_count] <= mem_o.wdata;
			wr_count <= wr_count + 1;
		end
	end

	// hang guard, the full run needs well under a thousand cycles
	always @(posedge core_clk_i) begin
		cycles <= cycles + 1;
		if (cycles == 5000) begin
			failures = failures + 1;
			final_report();
		end
	end

	task automatic final_report();
		$display("checks %0d mismatches %0d", check_count, failures);
		if (failures == 0 && check_count > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask

	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		check_count = check_count + 1;
		if (got !== exp) begin
			failures = failures + 1;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// avalon transfer: held until waitrequest is seen low at a rising edge
	task automatic av(input logic wr, input logic [2:0] a, input logic [31:0] d,
		output logic [31:0] q);
		int n;
		@(posedge core_clk_i);
		avs_address <= a;
		avs_writedata <= d;
		avs_read <= ~wr;
		avs_write <= wr;
		for (n = 0; n < 200; n++) begin
			@(posedge core_clk_i);
			if (avs_waitrequest === 1'b0) break;
		end
		if (n == 200) begin
			failures = failures + 1;
			$display("Error at %0t: bus transfer never answered", $time);
		end
		q = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		@(negedge core_clk_i);
	endtask

	// one decoder command, taken at the edge where ready is high
	task automatic cmd(input crs_op_e op, input crs_alu_e al, input logic [7:0] b,
		input logic [15:0] w);
		int n;
		@(posedge core_clk_i);
		cmd_valid_i <= 1'b1;
		cmd_i <= '{op: op, alu: al, byte_v: b, word_v: w};
		for (n = 0; n < 200; n++) begin
			@(posedge core_clk_i);
			if (cmd_ready_o === 1'b1) break;
		end
		cmd_valid_i <= 1'b0;
		@(negedge core_clk_i);
	endtask

	// bounded wait for the sequencer to return to run
	task automatic wait_ready();
		int n;
		for (n = 0; n < 50; n++) begin
			@(negedge core_clk_i);
			if (cmd_ready_o === 1'b1) break;
		end
	endtask

	// reset values, vector load and an unmapped word
	task automatic t_reset();
		av(1'b0, 3'h0, 32'h0, rd); check(rd, 32'h0000_0000);
		av(1'b0, 3'h2, 32'h0, rd); check(rd, 32'h0000_00ff);
		av(1'b0, 3'h3, 32'h0, rd); check(rd, 32'h0000_1234);
		check(32'(flags_o), 32'h0000_0068);
		av(1'b0, 3'h6, 32'h0, rd); check(rd, 32'h0000_0000);
		av(1'b0, 3'h5, 32'h0, rd); check(rd, 32'h0000_0003);
	endtask

	// index pointer bytes and both address forming modes
	task automatic t_index();
		cmd(CRS_OP_LD_H, CRS_ALU_ADD, 8'h3c, 16'h0000);
		cmd(CRS_OP_LD_X, CRS_ALU_ADD, 8'hc3, 16'h0000);
		av(1'b0, 3'h1, 32'h0, rd); check(rd, 32'h0000_3cc3);
		av(1'b1, 3'h1, 32'h0000_a55a, rd);
		av(1'b0, 3'h1, 32'h0, rd); check(rd, 32'h0000_a55a);
		cmd(CRS_OP_EA_IX, CRS_ALU_ADD, 8'h00, 16'h0010); check(32'(ea_o), 32'h0000_a56a);
		av(1'b1, 3'h2, 32'h0000_1234, rd);
		cmd(CRS_OP_EA_SP, CRS_ALU_ADD, 8'h00, 16'h0003); check(32'(ea_o), 32'h0000_1237);
	endtask

	// low byte reload, then push and pull of the index high byte
	task automatic t_stack();
		int base;
		cmd(CRS_OP_RSP, CRS_ALU_ADD, 8'h00, 16'h0000);
		av(1'b0, 3'h2, 32'h0, rd); check(rd, 32'h0000_12ff);
		base = wr_count;
		cmd(CRS_OP_PUSH_H, CRS_ALU_ADD, 8'h00, 16'h0000);
		check(32'(wr_addr[base]), 32'h0000_12ff);
		check(32'(wr_data[base]), 32'h0000_00a5);
		av(1'b0, 3'h2, 32'h0, rd); check(rd, 32'h0000_12fe);
		av(1'b1, 3'h1, 32'h0000_005a, rd);
		cmd(CRS_OP_PULL_H, CRS_ALU_ADD, 8'h00, 16'h0000);
		av(1'b0, 3'h2, 32'h0, rd); check(rd, 32'h0000_12ff);
		av(1'b0, 3'h1, 32'h0, rd); check(rd, 32'h0000_a55a);
	endtask

	// alu results and flags across overflow, carry, borrow and zero
	task automatic t_alu();
		crs_alu_e ops [9] = '{CRS_ALU_ADD, CRS_ALU_ADD, CRS_ALU_SUB, CRS_ALU_AND, CRS_ALU_ADC,
			CRS_ALU_ASL, CRS_ALU_LSR, CRS_ALU_EOR, CRS_ALU_ORA};
		logic [7:0] a [9] = '{8'h7f, 8'hff, 8'h00, 8'hf0, 8'h7f, 8'hc0, 8'h01, 8'hff, 8'h80};
		logic [7:0] m [9] = '{8'h01, 8'h01, 8'h01, 8'h0f, 8'h00, 8'h00, 8'h00, 8'hff, 8'h01};
		logic [7:0] r [9] = '{8'h80, 8'h00, 8'hff, 8'h00, 8'h80, 8'h80, 8'h00, 8'h00, 8'h81};
		logic [7:0] f [9] = '{8'hfc, 8'h7b, 8'h7d, 8'h7b, 8'hfc, 8'h7d, 8'hfb, 8'h7b, 8'h7d};
		int i;
		for (i = 0; i < 9; i++) begin
			av(1'b1, 3'h0, 32'(a[i]), rd);
			cmd(CRS_OP_ALU, ops[i], m[i], 16'h0000);
			av(1'b0, 3'h0, 32'h0, rd); check(rd, 32'(r[i]));
			check(32'(flags_o), 32'(f[i]));
		end
	endtask

	// sequential fetch after a jump
	task automatic t_flow();
		cmd(CRS_OP_JUMP, CRS_ALU_ADD, 8'h00, 16'h4320); check(32'(iaddr_o), 32'h0000_4320);
		cmd(CRS_OP_FETCH, CRS_ALU_ADD, 8'h00, 16'h0000); check(32'(iaddr_o), 32'h0000_4321);
	endtask

	// masked requests wait, then entry, frame, priority and return
	task automatic t_irq();
		logic [15:0] ea [5] = '{16'h0180, 16'h017f, 16'h017e, 16'h017d, 16'h017c};
		logic [7:0] ed [5] = '{8'h21, 8'h43, 8'h5a, 8'h11, 8'h60};
		int base;
		int i;
		av(1'b1, 3'h4, 32'h0000_0000, rd);
		check(32'(flags_o), 32'h0000_0068);
		av(1'b1, 3'h0, 32'h0000_0011, rd);
		av(1'b1, 3'h2, 32'h0000_0180, rd);
		base = wr_count;
		@(posedge core_clk_i);
		irq_i <= 4'h3;
		repeat (10) @(negedge core_clk_i);
		check(32'(cmd_ready_o), 32'h1);
		check(32'(wr_count - base), 32'h0);
		cmd(CRS_OP_CLI, CRS_ALU_ADD, 8'h00, 16'h0000);
		@(negedge core_clk_i);
		wait_ready();
		@(posedge core_clk_i);
		irq_i <= 4'h0;
		@(negedge core_clk_i);
		check(32'(wr_count - base), 32'h5);
		for (i = 0; i < 5; i++) begin
			check(32'(wr_addr[base + i]), 32'(ea[i]));
			check(32'(wr_data[base + i]), 32'(ed[i]));
		end
		check(32'(iaddr_o), 32'h0000_5678);
		check(32'(flags_o), 32'h0000_0068);
		av(1'b0, 3'h2, 32'h0, rd); check(rd, 32'h0000_017b);
		cmd(CRS_OP_RTI, CRS_ALU_ADD, 8'h00, 16'h0000);
		wait_ready();
		check(32'(flags_o), 32'h0000_0060);
		check(32'(iaddr_o), 32'h0000_4321);
		av(1'b0, 3'h2, 32'h0, rd); check(rd, 32'h0000_0180);
		av(1'b0, 3'h0, 32'h0, rd); check(rd, 32'h0000_0011);
		cmd(CRS_OP_SEI, CRS_ALU_ADD, 8'h00, 16'h0000); check(32'(flags_o), 32'h0000_0068);
	endtask

	// main sequence
	initial begin
		repeat (6) @(posedge core_clk_i);
		rst_n_i <= 1'b1;
		repeat (4) @(posedge core_clk_i);
		t_reset();
		t_index();
		t_stack();
		t_alu();
		t_flow();
		t_irq();
		final_report();
	end
endmodule
